/* ucg_pkg.sv */
// Package for the general control and status register bank of the USB device controller
package ucg_pkg;

  // ------------------------------------------------------------------
  // Register offsets (byte addresses)
  // ------------------------------------------------------------------
  localparam int          ADDR_W          = 12;
  localparam logic [11:0] OFF_GEN_CTRL    = 12'h800;
  localparam logic [11:0] OFF_GEN_STATUS  = 12'h804;
  localparam logic [11:0] OFF_STA_CLEAR   = 12'h808;
  localparam logic [11:0] OFF_STA_SET     = 12'h80c;
  localparam logic [11:0] OFF_VERSION     = 12'h818;
  localparam logic [11:0] OFF_FEATURES    = 12'h81c;
  localparam logic [11:0] OFF_WINDOW_SIZE = 12'h820;
  localparam logic [11:0] OFF_NAME_LOW    = 12'h824;
  localparam logic [11:0] OFF_NAME_HIGH   = 12'h828;

  // ------------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------------
  localparam int BIT_CTRL_ENABLE = 15;
  localparam int BIT_CLK_FREEZE  = 14;
  localparam int BIT_GCLK_USABLE = 14;
  localparam int BIT_SPEED_LO    = 12;
  localparam int POS_VARIANT     = 16;

  // ------------------------------------------------------------------
  // Encodings and reset values
  // ------------------------------------------------------------------
  localparam logic [1:0]  SPEED_FULL      = 2'h0;
  localparam logic [1:0]  SPEED_LOW       = 2'h2;
  localparam logic        RST_CTRL_ENABLE = 1'h0;
  localparam logic        RST_CLK_FREEZE  = 1'h0;
  localparam logic [31:0] RST_ZERO        = 32'h0000_0000;

endpackage : ucg_pkg

/* ucg_general_regs.sv */
// General control, status and identification registers of the USB device controller
`timescale 1ns/1ns
// ------------------------------------------------------------------
// Functional notes
// - Writing enable to zero turns off controller, transceiver and USB clocks, overriding freeze but keeping its value.
// - While disabled, the other registers sit at their reset values and ignore writes.
// - Writing enable to one turns the controller on, and the bit reads back the enable state.
// - The enable bit accepts writes even while the clock is frozen.
// - Setting freeze gates the USB clocks off while resume detection stays active.
// - While frozen, the other registers ignore writes; the speed field keeps its value, but the clock usable bit still follows clock edges.
// - Writing freeze to zero restarts the USB clocks, and the bit reads zero while they run.
// - The freeze bit accepts writes even while the controller is disabled.
// - Status bit 14 shows whether the 48 MHz generic clock is usable.
// - The two-bit speed field reads 00 for full speed and 10 for low speed, never 01 or 11.
// - A one written to bit 14 of the clear alias clears the clock usable bit, other bits do nothing, and it reads zero.
// - A one written to bit 14 of the set alias sets the clock usable bit, other bits do nothing, and it reads zero.
// - The version register shows a 12-bit version and a variant field with no effect on behaviour.
// - The features register shows the number of implemented endpoints in its low field.
// - The window size register reads the size of the bus space given to the controller.
// - Two name registers hold the ASCII module name, first part at the lower address.
// ------------------------------------------------------------------
module ucg_general_regs #(
  parameter logic [11:0] VERSION_NUM    = 12'h001,
  parameter logic [3:0]  VARIANT_NUM    = 4'h0,
  parameter logic [3:0]  ENDPOINT_COUNT = 4'h8,
  parameter logic [31:0] WINDOW_SIZE    = 32'h0000_1000,
  // Name text is arbitrary
  parameter logic [31:0] NAME_LOW       = 32'h5553_4244,
  parameter logic [31:0] NAME_HIGH      = 32'h4556_2020
) (
  input  wire logic                      clk_sys_i,
  input  wire logic                      nrst_i,
  input  wire logic                      reg_sel_i,
  input  wire logic                      reg_wr_i,
  input  wire logic [ucg_pkg::ADDR_W-1:0] reg_addr_i,
  input  wire logic [31:0]               reg_wdata_i,
  output logic      [31:0]               reg_rdata_o,
  output logic                           reg_ack_o,
  input  wire logic                      gclk_ok_i,
  input  wire logic                      low_speed_i,
  output logic                           controller_enable_o,
  output logic                           transceiver_enable_o,
  output logic                           usb_clk_enable_o,
  output logic                           resume_detect_enable_o
);
  import ucg_pkg::*;

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  typedef struct packed {
    logic        controller_enable;
    logic        clock_freeze;
    logic        gclk_meta;
    logic        gclk_sync;
    logic        gclk_prev;
    logic        gclk_usable_flag;
    logic        low_speed;
    logic [31:0] rdata;
    logic        ack;
  } ucg_state_t;

  ucg_state_t state_r;
  ucg_state_t state_nxt;

  function automatic logic hit(input logic [ADDR_W-1:0] addr, input logic [ADDR_W-1:0] off);
    hit = (addr == off);
  endfunction

  logic        wr_ok;
  logic        regs_locked;
  logic [31:0] ctrl_view;
  logic [31:0] status_view;
  logic [31:0] rd_mux;

  // ------------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------------
  always_comb begin
    state_nxt   = state_r;
    wr_ok       = reg_sel_i && reg_wr_i;
    // Locked registers ignore writes silently, the access still acks
    regs_locked = !state_r.controller_enable || state_r.clock_freeze;

    state_nxt.gclk_meta = gclk_ok_i;
    state_nxt.gclk_sync = state_r.gclk_meta;
    state_nxt.gclk_prev = state_r.gclk_sync;

    // Enable and freeze stay writable in every state
    if (wr_ok && hit(reg_addr_i, OFF_GEN_CTRL)) begin
      state_nxt.controller_enable = reg_wdata_i[BIT_CTRL_ENABLE];
      state_nxt.clock_freeze      = reg_wdata_i[BIT_CLK_FREEZE];
    end

    // Clock usable flag follows edges of the synchronised level
    if (state_r.gclk_prev && !state_r.gclk_sync) begin
      state_nxt.gclk_usable_flag = 1'b0;
    end
    if (!regs_locked && wr_ok && hit(reg_addr_i, OFF_STA_CLEAR)
        && reg_wdata_i[BIT_GCLK_USABLE]) begin
      state_nxt.gclk_usable_flag = 1'b0;
    end
    if (!regs_locked && wr_ok && hit(reg_addr_i, OFF_STA_SET)
        && reg_wdata_i[BIT_GCLK_USABLE]) begin
      state_nxt.gclk_usable_flag = 1'b1;
    end
    // A hardware set placed after the alias writes so it wins over a same-cycle clear
    if (!state_r.gclk_prev && state_r.gclk_sync) begin
      state_nxt.gclk_usable_flag = 1'b1;
    end

    // Frozen clocks stop tracking speed, the last value is kept
    if (!state_r.clock_freeze) begin
      state_nxt.low_speed = low_speed_i;
    end

    // Disabled controller holds status in reset, freeze value kept
    if (!state_r.controller_enable) begin
      state_nxt.gclk_usable_flag = 1'b0;
      state_nxt.low_speed        = 1'b0;
    end

    state_nxt.ack   = reg_sel_i;
    state_nxt.rdata = (reg_sel_i && !reg_wr_i) ? rd_mux : RST_ZERO;
  end

  // ------------------------------------------------------------------
  // Read views
  // ------------------------------------------------------------------
  always_comb begin
    ctrl_view                  = RST_ZERO;
    ctrl_view[BIT_CTRL_ENABLE] = state_r.controller_enable;
    ctrl_view[BIT_CLK_FREEZE]  = state_r.clock_freeze;

    status_view                  = RST_ZERO;
    status_view[BIT_GCLK_USABLE] = state_r.gclk_usable_flag;
    // Only the two legal patterns can be built here
    status_view[BIT_SPEED_LO +: 2] = state_r.low_speed ? SPEED_LOW : SPEED_FULL;

    rd_mux = RST_ZERO; // Aliases and unmapped offsets read zero
    if (hit(reg_addr_i, OFF_GEN_CTRL)) begin
      rd_mux = ctrl_view;
    end
    if (hit(reg_addr_i, OFF_GEN_STATUS)) begin
      rd_mux = status_view;
    end
    if (hit(reg_addr_i, OFF_VERSION)) begin
      rd_mux[11:0]                 = VERSION_NUM;
      rd_mux[POS_VARIANT +: 4]     = VARIANT_NUM;
    end
    if (hit(reg_addr_i, OFF_FEATURES)) begin
      rd_mux[3:0] = ENDPOINT_COUNT;
    end
    if (hit(reg_addr_i, OFF_WINDOW_SIZE)) begin
      rd_mux = WINDOW_SIZE;
    end
    if (hit(reg_addr_i, OFF_NAME_LOW)) begin
      rd_mux = NAME_LOW;
    end
    if (hit(reg_addr_i, OFF_NAME_HIGH)) begin
      rd_mux = NAME_HIGH;
    end
  end

  // ------------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      state_r                   <= '0;
      state_r.controller_enable <= RST_CTRL_ENABLE;
      state_r.clock_freeze      <= RST_CLK_FREEZE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------
  assign reg_rdata_o          = state_r.rdata;
  assign reg_ack_o            = state_r.ack;
  assign controller_enable_o  = state_r.controller_enable;
  assign transceiver_enable_o = state_r.controller_enable;
  // Disable overrides freeze; freeze only gates the clocks
  assign usb_clk_enable_o     = state_r.controller_enable && !state_r.clock_freeze;
  // Resume detection must survive freeze so the bus can wake the block
  assign resume_detect_enable_o = state_r.controller_enable;

endmodule // ucg_general_regs

/* ucg_regs_chk.sv */
// Assertion checker for the general register bank of the USB device controller
`timescale 1ns/1ns
module ucg_regs_chk
  import ucg_pkg::*;
(
  input wire logic        clk_sys_i,
  input wire logic        nrst_i,
  input wire logic        reg_sel_i,
  input wire logic        reg_wr_i,
  input wire logic [11:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic [31:0] reg_rdata_o,
  input wire logic        reg_ack_o,
  input wire logic        gclk_ok_i,
  input wire logic        low_speed_i,
  input wire logic        controller_enable_o,
  input wire logic        transceiver_enable_o,
  input wire logic        usb_clk_enable_o,
  input wire logic        resume_detect_enable_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);
  sequence s_ctrl_wr;
    reg_sel_i && reg_wr_i && reg_addr_i == OFF_GEN_CTRL;
  endsequence
  sequence s_rd(logic [11:0] a);
    reg_sel_i && !reg_wr_i && reg_addr_i == a;
  endsequence
  // Two disabled cycles, the read in the second, so the forced clear of the status has landed
  sequence s_off_status_rd;
    !controller_enable_o ##1 (!controller_enable_o && reg_sel_i && !reg_wr_i
      && reg_addr_i == OFF_GEN_STATUS);
  endsequence
  a_ack_one_cycle: assert property (reg_sel_i |=> reg_ack_o) else $error("ack late");
  a_wr_no_data: assert property (reg_sel_i && reg_wr_i |=> reg_rdata_o == 32'h0000_0000)
    else $error("write gave data");
  a_alias_rd_zero: assert property (s_rd(OFF_STA_CLEAR) or s_rd(OFF_STA_SET)
    |=> reg_rdata_o == 32'h0000_0000) else $error("alias read not zero");
  a_xcvr_tracks: assert property (transceiver_enable_o == controller_enable_o)
    else $error("transceiver enable wrong");
  a_resume_live: assert property (resume_detect_enable_o == controller_enable_o)
    else $error("resume detect wrong");
  a_clk_needs_en: assert property (usb_clk_enable_o |-> controller_enable_o)
    else $error("clock on while disabled");
  a_enable_wr: assert property (s_ctrl_wr |=> controller_enable_o == $past(reg_wdata_i[15]))
    else $error("enable not written");
  a_freeze_gate: assert property (s_ctrl_wr |=> usb_clk_enable_o ==
    ($past(reg_wdata_i[15]) && !$past(reg_wdata_i[14]))) else $error("clock gate wrong");
  a_speed_legal: assert property (s_rd(OFF_GEN_STATUS) |=> !reg_rdata_o[12])
    else $error("reserved speed code");
  a_off_status: assert property (s_off_status_rd |=> reg_rdata_o == 32'h0000_0000)
    else $error("status not reset while disabled");
endmodule // ucg_regs_chk
bind ucg_general_regs ucg_regs_chk u_chk (.*);

/* ucg_far_side.sv */
// Model of the generic clock source and speed selection beside the register bank
`timescale 1ns/1ns
module ucg_far_side (
  input  wire logic clk_ok_req_i,
  input  wire logic low_req_i,
  output logic      gclk_ok_o,
  output logic      low_speed_o
);
  initial gclk_ok_o = 1'b0;
  // Clock health moves off the system clock grid, as a real source does
  always @(clk_ok_req_i) gclk_ok_o <= #3 clk_ok_req_i;
  always_comb low_speed_o = low_req_i;
endmodule // ucg_far_side

/* ucg_general_regs_tb_top.sv */
// Self-checking testbench for the general register bank of the USB device controller
`timescale 1ns/1ns
module ucg_general_regs_tb_top;
  import ucg_pkg::*;
  logic clk_sys_i = 1'b0, nrst_i = 1'b0, reg_sel_i = 1'b0, reg_wr_i = 1'b0;
  logic ok_req = 1'b0, ls_req = 1'b0, gclk_ok_i, low_speed_i, reg_ack_o;
  logic controller_enable_o, transceiver_enable_o, usb_clk_enable_o, resume_detect_enable_o;
  logic [11:0] reg_addr_i = 12'h000;
  logic [31:0] reg_wdata_i = 32'h0000_0000, reg_rdata_o, q[$];
  int num_errors = 0, tests_run = 0;
  localparam logic [11:0] IDA[6] = '{OFF_VERSION, OFF_FEATURES, OFF_WINDOW_SIZE,
    OFF_NAME_LOW, OFF_NAME_HIGH, 12'h7fc};
  localparam logic [31:0] IDV[6] = '{32'h0003_00a5, 32'h0000_0005, 32'h0000_1000,
    32'h5553_4244, 32'h4556_2020, 32'h0000_0000};
  always #2 clk_sys_i = ~clk_sys_i;
  ucg_far_side far (.clk_ok_req_i(ok_req), .low_req_i(ls_req), .gclk_ok_o(gclk_ok_i),
    .low_speed_o(low_speed_i));
  ucg_general_regs #(.VERSION_NUM(12'h0a5), .VARIANT_NUM(4'h3), .ENDPOINT_COUNT(4'h5)) uut (.*);
  task automatic end_sim();
    if (num_errors == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk_rd(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t read %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_pin(input logic [3:0] exp);
    tests_run++;
    if ({controller_enable_o, transceiver_enable_o, usb_clk_enable_o,
        resume_detect_enable_o} !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t enable pins exp %b", $time, exp);
    end
  endtask
  // Back-to-back calls keep the select high, one access per cycle
  task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [31:0] e);
    reg_sel_i <= 1'b1;
    reg_wr_i <= w;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    q.push_back(w ? 32'h0000_0000 : e);
    @(posedge clk_sys_i);
  endtask
  task automatic idle(input int n);
    reg_sel_i <= 1'b0;
    repeat (n) @(posedge clk_sys_i);
  endtask
  always @(negedge clk_sys_i) if (reg_ack_o === 1'b1) chk_rd(reg_rdata_o, q.pop_front());
  // About 74 cycles of traffic; the 1250-cycle limit, some seventeen times that, means a hang
  initial begin
    #5000;
    num_errors++;
    end_sim();
  end
  initial begin
    void'($urandom(32'h24a0));
    repeat (3) @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    acc(0, OFF_GEN_CTRL, 32'h0000_0000, 32'h0000_0000);
    for (int i = 0; i < 6; i++) begin
      acc(1, IDA[i], $urandom, 32'h0000_0000);
      acc(0, IDA[i], 32'h0000_0000, IDV[i]);
    end
    ok_req <= 1'b1;
    idle(6);
    acc(1, OFF_STA_SET, 32'h0000_4000, 32'h0000_0000);
    acc(0, OFF_GEN_STATUS, 32'h0000_0000, 32'h0000_0000);
    ok_req <= 1'b0;
    ls_req <= 1'b1;
    idle(6);
    acc(1, OFF_GEN_CTRL, 32'h0000_8000, 32'h0000_0000);
    acc(0, OFF_GEN_CTRL, 32'h0000_0000, 32'h0000_8000);
    ok_req <= 1'b1;
    idle(8);
    acc(0, OFF_GEN_STATUS, 32'h0000_0000, 32'h0000_6000);
    ok_req <= 1'b0;
    idle(8);
    acc(0, OFF_GEN_STATUS, 32'h0000_0000, 32'h0000_2000);
    acc(1, OFF_STA_SET, 32'h0000_4000, 32'h0000_0000);
    acc(0, OFF_GEN_STATUS, 32'h0000_0000, 32'h0000_6000);
    acc(0, OFF_STA_SET, 32'h0000_0000, 32'h0000_0000);
    acc(1, OFF_STA_CLEAR, $urandom | 32'h0000_4000, 32'h0000_0000);
    acc(0, OFF_GEN_STATUS, 32'h0000_0000, 32'h0000_2000);
    acc(0, OFF_STA_CLEAR, 32'h0000_0000, 32'h0000_0000);
    acc(1, OFF_GEN_CTRL, 32'h0000_c000, 32'h0000_0000);
    idle(1);
    chk_pin(4'b1101);
    acc(1, OFF_STA_SET, 32'h0000_4000, 32'h0000_0000);
    ls_req <= 1'b0;
    idle(3);
    acc(0, OFF_GEN_STATUS, 32'h0000_0000, 32'h0000_2000);
    acc(1, OFF_GEN_CTRL, 32'h0000_4000, 32'h0000_0000);
    idle(1);
    chk_pin(4'b0000);
    acc(0, OFF_GEN_CTRL, 32'h0000_0000, 32'h0000_4000);
    acc(0, OFF_GEN_STATUS, 32'h0000_0000, 32'h0000_0000);
    acc(1, OFF_GEN_CTRL, 32'h0000_0000, 32'h0000_0000);
    acc(0, OFF_GEN_CTRL, 32'h0000_0000, 32'h0000_0000);
    acc(1, OFF_GEN_CTRL, 32'h0000_8000, 32'h0000_0000);
    idle(1);
    chk_pin(4'b1111);
    idle(3);
    end_sim();
  end
endmodule // ucg_general_regs_tb_top
